//--- hw/voice_regs_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the voice control bank
// Assumes: 6-bit register address, 8-bit register data
// Notes: bits that power up undefined are cleared here so reset state is fully known
`ifndef VOICE_REGS_DEFS_SVH
`define VOICE_REGS_DEFS_SVH

// ==========================================================
// register offsets
`define GAIN_ADDR 6'h19
`define LOW_TONE_FREQUENCY_WORD_ADDR 6'h1a
`define HIGH_TONE_FREQUENCY_WORD_ADDR 6'h1b
`define HOWL_CTL_ADDR 6'h1c
`define UPPER_THR_ADDR 6'h1d
`define LOWER_THR_ADDR 6'h1e
`define RESERVED_FIRST 6'h1f
`define RESERVED_LAST 6'h3f

// ==========================================================
// reset values
`define GAIN_RESET 8'h88
`define LOW_TONE_FREQUENCY_WORD_RESET 8'h00
`define HIGH_TONE_FREQUENCY_WORD_RESET 8'h00
`define HOWL_CTL_RESET 8'h24
`define UPPER_THR_RESET 8'h30
`define LOWER_THR_RESET 8'h14

// ==========================================================
// field positions
`define TX_GAIN_HI 7
`define TX_GAIN_LO 4
`define RX_GAIN_HI 3
`define RX_GAIN_LO 0
`define HOWL_EN_BIT 7
`define MODE_HI 5
`define MODE_LO 4
`define PAD_HI 2
`define PAD_LO 0
`define THR_HI 6

// ==========================================================
// scaling and timing
`define GAIN_STEP_DB 6'h03
`define GAIN_FLOOR_DB 6'h18
`define PAD_STEP_DB 5'h03
`define CLOCK_HZ 50000000
`define SAMPLE_HZ 8000
`define SAMPLE_DIV (`CLOCK_HZ / `SAMPLE_HZ)
`define TONE_ACC_W 10

`endif

//--- hw/voice_regs_pkg.sv
// Purpose: types shared by the voice control bank and its helpers
// Assumes: constants come from voice_regs_defs.svh
// Notes: all state records are packed so each module registers one word
package voice_regs_pkg;

    // ==========================================================
    // anti-howl operating modes, in field order 00..11
    typedef enum logic [1:0] {
        tx_squelch,
        rx_squelch,
        group_listen,
        switched_loss
    } howl_mode_t;

    // ==========================================================
    // state records
    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] low_tone_frequency_word;
        logic [7:0] high_tone_frequency_word;
        logic [7:0] howl_ctl;
        logic [7:0] upper_thr;
        logic [7:0] lower_thr;
        logic [7:0] rdata;
        logic [15:0] div_cnt;
        logic tick;
        logic [5:0] tx_db;
        logic [5:0] rx_db;
        logic [4:0] pad_db;
        logic [4:0] tx_att;
        logic [4:0] rx_att;
    } bank_state_t;

    typedef struct packed {
        logic [15:0] phase;
    } tone_state_t;

    typedef struct packed {
        logic active;
    } howl_state_t;

endpackage

//--- hw/tone_phase_gen.sv
// Purpose: phase accumulator for one tone group, stepped once per sample
// Assumes: sample_tick is a one-cycle pulse at the sample rate on mclk
// Notes: with a 10-bit accumulator at 8 kHz one code is 7.8125 Hz
`timescale 1ns/1ps
`default_nettype none
`include "voice_regs_defs.svh"

module tone_phase_gen
    import voice_regs_pkg::*;
#(
    parameter int ACC_W = `TONE_ACC_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_tick,
    input wire logic enable,
    input wire logic [7:0] freq_word,
    output logic [ACC_W-1:0] phase,
    output logic wave
);
    if (ACC_W < 8 || ACC_W > 16) begin : g_bad_width
        $error("tone accumulator width out of range");
    end

    tone_state_t st;
    tone_state_t next_st;

    // ==========================================================
    // accumulator: new word is used on the very next sample
    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st.phase = '0;
        end else if (sample_tick) begin
            next_st.phase[ACC_W-1:0] = st.phase[ACC_W-1:0] + ACC_W'(freq_word);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign phase = st.phase[ACC_W-1:0];
    assign wave = st.phase[ACC_W-1];

    // ==========================================================
    // checks
    a_tone_idle_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        !enable |=> phase == '0) else $error("tone phase not cleared when off");
    a_tone_step_word: assert property (@(posedge mclk) disable iff (!rst_n)
        enable && sample_tick |=> phase == ACC_W'($past(phase) + ACC_W'($past(freq_word))))
        else $error("tone phase step differs from word");
endmodule
`default_nettype wire

//--- hw/howl_hysteresis.sv
// Purpose: speech activity decision with hysteresis for the anti-howl pads
// Assumes: level is a sign-magnitude magnitude (chord, step) on mclk
// Notes: chord/step codes are monotonic, so plain unsigned compare orders them
`timescale 1ns/1ps
`default_nettype none

module howl_hysteresis
    import voice_regs_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic sample_tick,
    input wire logic enable,
    input wire logic [6:0] level,
    input wire logic [6:0] upper,
    input wire logic [6:0] lower,
    output logic active
);
    howl_state_t st;
    howl_state_t next_st;

    // ==========================================================
    // between the thresholds the previous decision holds
    always_comb begin
        next_st = st;
        if (!enable) begin
            next_st.active = 1'b0;
        end else if (sample_tick) begin
            if (level > upper) begin
                next_st.active = 1'b1;
            end else if (level < lower) begin
                next_st.active = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign active = st.active;

    a_howl_band_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        enable && (level <= upper) && (level >= lower) |=> active == $past(active))
        else $error("decision moved inside hysteresis band");
    a_howl_rise_set: assert property (@(posedge mclk) disable iff (!rst_n)
        enable && sample_tick && level > upper |=> active)
        else $error("level above upper threshold not detected");
endmodule
`default_nettype wire

//--- hw/gain_tone_antihowl_regs.sv
// Purpose: gain, tone coefficient and anti-howl control registers with their decode
// Assumes: register port and speech level are synchronous to mclk
// Notes: reads return data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
`include "voice_regs_defs.svh"

module gain_tone_antihowl_regs
    import voice_regs_pkg::*;
#(
    parameter int SAMPLE_DIV = `SAMPLE_DIV,
    parameter int ACC_W = `TONE_ACC_W
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [5:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] speech_level,
    input wire logic lower_group_tone_on,
    input wire logic upper_group_tone_on,
    output logic [3:0] transmit_gain_code,
    output logic [3:0] receive_gain_code,
    output logic signed [5:0] tx_gain_db,
    output logic signed [5:0] rx_gain_db,
    output logic [7:0] lower_tone_frequency_word,
    output logic [7:0] upper_tone_frequency_word,
    output logic [ACC_W-1:0] lower_tone_phase,
    output logic [ACC_W-1:0] upper_tone_phase,
    output logic lower_tone_wave,
    output logic upper_tone_wave,
    output logic howl_enable,
    output howl_mode_t howl_mode_select,
    output logic [2:0] attenuation_depth,
    output logic [4:0] attenuation_db,
    output logic [6:0] upper_threshold_level,
    output logic [6:0] lower_threshold_level,
    output logic speech_active,
    output logic [4:0] tx_atten_db,
    output logic [4:0] rx_atten_db,
    output logic sample_tick
);
    // ==========================================================
    // elaboration checks
    if (SAMPLE_DIV < 2 || SAMPLE_DIV > 65536) begin : g_bad_div
        $error("sample divider out of range");
    end
    if (ACC_W != `TONE_ACC_W) begin : g_bad_acc
        $error("accumulator width must keep 7.8125 Hz per code");
    end

    localparam logic [15:0] DIV_LAST = 16'(SAMPLE_DIV - 1);

    bank_state_t st;
    bank_state_t next_st;
    howl_mode_t mode;
    logic [1:0] tone_on;
    logic [7:0] tone_word [2];
    logic [ACC_W-1:0] tone_phase [2];
    logic [1:0] tone_wave;
    logic active;

    assign mode = howl_mode_t'(st.howl_ctl[`MODE_HI:`MODE_LO]);

    // ==========================================================
    // register writes, reads and decode
    always_comb begin
        next_st = st;

        // sample strobe for the tone and level logic
        next_st.tick = 1'b0;
        if (st.div_cnt == DIV_LAST) begin
            next_st.div_cnt = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.div_cnt = st.div_cnt + 16'h0001;
        end

        // reserved and lower addresses fall through and read as zero
        if (reg_rd) begin
            case (reg_addr)
                `GAIN_ADDR: next_st.rdata = st.gain;
                `LOW_TONE_FREQUENCY_WORD_ADDR: next_st.rdata = st.low_tone_frequency_word;
                `HIGH_TONE_FREQUENCY_WORD_ADDR: next_st.rdata = st.high_tone_frequency_word;
                `HOWL_CTL_ADDR: next_st.rdata = st.howl_ctl;
                `UPPER_THR_ADDR: next_st.rdata = st.upper_thr;
                `LOWER_THR_ADDR: next_st.rdata = st.lower_thr;
                default: next_st.rdata = 8'h00;
            endcase
        end

        if (reg_wr) begin
            case (reg_addr)
                `GAIN_ADDR: next_st.gain = reg_wdata;
                `LOW_TONE_FREQUENCY_WORD_ADDR: next_st.low_tone_frequency_word = reg_wdata;
                `HIGH_TONE_FREQUENCY_WORD_ADDR: next_st.high_tone_frequency_word = reg_wdata;
                `HOWL_CTL_ADDR: next_st.howl_ctl = reg_wdata;
                `UPPER_THR_ADDR: next_st.upper_thr = reg_wdata;
                `LOWER_THR_ADDR: next_st.lower_thr = reg_wdata;
                default: next_st.gain = st.gain;
            endcase
        end

        // gain in dB: code * 3 - 24, wraps into 6-bit two's complement
        next_st.tx_db = 6'({2'b00, st.gain[`TX_GAIN_HI:`TX_GAIN_LO]} * `GAIN_STEP_DB
            - `GAIN_FLOOR_DB);
        next_st.rx_db = 6'({2'b00, st.gain[`RX_GAIN_HI:`RX_GAIN_LO]} * `GAIN_STEP_DB
            - `GAIN_FLOOR_DB);
        next_st.pad_db = 5'({2'b00, st.howl_ctl[`PAD_HI:`PAD_LO]} * `PAD_STEP_DB);

        // which path takes the pad depends on mode and speech decision
        next_st.tx_att = 5'h00;
        next_st.rx_att = 5'h00;
        if (st.howl_ctl[`HOWL_EN_BIT]) begin
            case (mode)
                tx_squelch: begin
                    if (!active) begin
                        next_st.tx_att = st.pad_db;
                    end
                end
                rx_squelch: begin
                    if (!active) begin
                        next_st.rx_att = st.pad_db;
                    end
                end
                group_listen: begin
                    if (active) begin
                        next_st.rx_att = st.pad_db;
                    end
                end
                switched_loss: begin
                    if (active) begin
                        next_st.rx_att = st.pad_db;
                    end else begin
                        next_st.tx_att = st.pad_db;
                    end
                end
                default: begin
                    next_st.tx_att = 5'h00;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st <= '0;
            st.gain <= `GAIN_RESET;
            st.low_tone_frequency_word <= `LOW_TONE_FREQUENCY_WORD_RESET;
            st.high_tone_frequency_word <= `HIGH_TONE_FREQUENCY_WORD_RESET;
            st.howl_ctl <= `HOWL_CTL_RESET;
            st.upper_thr <= `UPPER_THR_RESET;
            st.lower_thr <= `LOWER_THR_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ==========================================================
    // tone generators, one per group
    assign tone_on = {upper_group_tone_on, lower_group_tone_on};
    assign tone_word[0] = st.low_tone_frequency_word;
    assign tone_word[1] = st.high_tone_frequency_word;

    for (genvar g = 0; g < 2; g++) begin : g_tone
        tone_phase_gen #(
            .ACC_W(ACC_W)
        ) u_tone (
            .mclk(mclk),
            .rst_n(rst_n),
            .sample_tick(st.tick),
            .enable(tone_on[g]),
            .freq_word(tone_word[g]),
            .phase(tone_phase[g]),
            .wave(tone_wave[g])
        );
    end

    // ==========================================================
    // anti-howl level decision
    howl_hysteresis u_howl (
        .mclk(mclk),
        .rst_n(rst_n),
        .sample_tick(st.tick),
        .enable(st.howl_ctl[`HOWL_EN_BIT]),
        .level(speech_level),
        .upper(st.upper_thr[`THR_HI:0]),
        .lower(st.lower_thr[`THR_HI:0]),
        .active(active)
    );

    // ==========================================================
    // outputs, all straight from state flops
    assign reg_rdata = st.rdata;
    assign transmit_gain_code = st.gain[`TX_GAIN_HI:`TX_GAIN_LO];
    assign receive_gain_code = st.gain[`RX_GAIN_HI:`RX_GAIN_LO];
    assign tx_gain_db = st.tx_db;
    assign rx_gain_db = st.rx_db;
    assign lower_tone_frequency_word = st.low_tone_frequency_word;
    assign upper_tone_frequency_word = st.high_tone_frequency_word;
    assign lower_tone_phase = tone_phase[0];
    assign upper_tone_phase = tone_phase[1];
    assign lower_tone_wave = tone_wave[0];
    assign upper_tone_wave = tone_wave[1];
    assign howl_enable = st.howl_ctl[`HOWL_EN_BIT];
    assign howl_mode_select = mode;
    assign attenuation_depth = st.howl_ctl[`PAD_HI:`PAD_LO];
    assign attenuation_db = st.pad_db;
    assign upper_threshold_level = st.upper_thr[`THR_HI:0];
    assign lower_threshold_level = st.lower_thr[`THR_HI:0];
    assign speech_active = active;
    assign tx_atten_db = st.tx_att;
    assign rx_atten_db = st.rx_att;
    assign sample_tick = st.tick;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_gain_reset_zero: assert property (!$past(rst_n) |-> reg_rdata == 8'h00
        && transmit_gain_code == 4'h8 && receive_gain_code == 4'h8)
        else $error("gain not 0 dB after reset");
    a_howl_reset_value: assert property (!$past(rst_n) |-> !howl_enable
        && howl_mode_select == group_listen)
        else $error("anti-howl control reset wrong");
    a_pad_reset_twelve: assert property (!$past(rst_n) |-> attenuation_depth == 3'h4)
        else $error("pad not 12 dB after reset");
    a_thr_reset_values: assert property (!$past(rst_n)
        |-> upper_threshold_level == 7'h30 && lower_threshold_level == 7'h14)
        else $error("threshold reset wrong");
    a_gain_nibble_map: assert property (reg_wr && reg_addr == `GAIN_ADDR
        |=> receive_gain_code == $past(reg_wdata[3:0])
        && transmit_gain_code == $past(reg_wdata[7:4]))
        else $error("gain nibbles swapped");
    a_gain_db_scale: assert property (reg_wr && reg_addr == `GAIN_ADDR
        ##1 !(reg_wr && reg_addr == `GAIN_ADDR)
        |=> tx_gain_db == $signed(6'($past(reg_wdata[7:4], 2) * 3)) - 6'sd24)
        else $error("transmit gain dB wrong");
    a_pad_db_scale: assert property (##1 $stable(attenuation_depth)
        |-> attenuation_db == 5'($past(attenuation_depth) * 3))
        else $error("pad dB wrong");
    a_write_read_back: assert property (reg_wr && reg_addr == `LOW_TONE_FREQUENCY_WORD_ADDR
        ##1 reg_rd && !reg_wr && reg_addr == `LOW_TONE_FREQUENCY_WORD_ADDR
        |=> reg_rdata == $past(reg_wdata, 2))
        else $error("read back differs from write");
    a_reserved_reads_zero: assert property (reg_rd && reg_addr >= `RESERVED_FIRST
        |=> reg_rdata == 8'h00)
        else $error("reserved address returned data");
    a_howl_off_flat: assert property (!howl_enable
        |=> tx_atten_db == 5'h00 && rx_atten_db == 5'h00)
        else $error("attenuation while anti-howl off");
    a_group_listen_pad: assert property (howl_enable && howl_mode_select == group_listen
        && speech_active |=> rx_atten_db == $past(attenuation_db) && tx_atten_db == 5'h00)
        else $error("group listening pad misrouted");

    c_gain_write: cover property (reg_wr && reg_addr == `GAIN_ADDR && reg_wdata == 8'h89);
    c_tone_running: cover property (lower_group_tone_on && sample_tick ##1 lower_tone_phase != '0);
    c_pad_inserted: cover property (howl_enable && rx_atten_db != 5'h00);
    c_tone_frequency_word_change: cover property (upper_group_tone_on && reg_wr
        && reg_addr == `HIGH_TONE_FREQUENCY_WORD_ADDR);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Purpose: self-checking bench for the gain, tone and anti-howl register bank
// Assumes: SAMPLE_DIV shortened to 4 so sample ticks come every few cycles
// Notes: the driver queues expected read data, a monitor matches it to reg_rdata
`timescale 1ns/1ps
`default_nettype none
`include "voice_regs_defs.svh"

module testbench;
    import voice_regs_pkg::*;
    // ==========================================================
    // stimulus and design outputs
    localparam logic [6:0] LV [8] = '{7'h31, 7'h20, 7'h30, 7'h14, 7'h13, 7'h20, 7'h30, 7'h31};
    localparam logic [7:0] ST = 8'b10001111;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [6:0] speech_level = 7'h00;
    logic lo_on = 1'b0;
    logic hi_on = 1'b0;
    logic [7:0] reg_rdata, lower_tone_frequency_word, upper_tone_frequency_word;
    logic [3:0] transmit_gain_code, receive_gain_code;
    logic signed [5:0] tx_gain_db, rx_gain_db;
    logic [9:0] lower_tone_phase, upper_tone_phase, p_lo, p_hi;
    logic lower_tone_wave, upper_tone_wave, howl_enable, speech_active, sample_tick;
    howl_mode_t howl_mode_select;
    logic [2:0] attenuation_depth;
    logic [4:0] attenuation_db, tx_atten_db, rx_atten_db;
    logic [6:0] upper_threshold_level, lower_threshold_level;
    int n_fail = 0;
    int n_compared = 0;
    int r, pad, tx_e, rx_e;
    logic [7:0] shadow [0:63];
    logic [7:0] exp_q [$];
    logic seen_rd = 1'b0;

    gain_tone_antihowl_regs #(.SAMPLE_DIV(4), .ACC_W(10)) u_dut (
        .mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .speech_level(speech_level),
        .lower_group_tone_on(lo_on), .upper_group_tone_on(hi_on),
        .transmit_gain_code(transmit_gain_code), .receive_gain_code(receive_gain_code),
        .tx_gain_db(tx_gain_db), .rx_gain_db(rx_gain_db),
        .lower_tone_frequency_word(lower_tone_frequency_word),
        .upper_tone_frequency_word(upper_tone_frequency_word),
        .lower_tone_phase(lower_tone_phase), .upper_tone_phase(upper_tone_phase),
        .lower_tone_wave(lower_tone_wave), .upper_tone_wave(upper_tone_wave),
        .howl_enable(howl_enable), .howl_mode_select(howl_mode_select),
        .attenuation_depth(attenuation_depth), .attenuation_db(attenuation_db),
        .upper_threshold_level(upper_threshold_level),
        .lower_threshold_level(lower_threshold_level), .speech_active(speech_active),
        .tx_atten_db(tx_atten_db), .rx_atten_db(rx_atten_db), .sample_tick(sample_tick)
    );

    always #10 mclk = ~mclk;

    // ==========================================================
    // checking and verdict
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        if (n_fail == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    always @(posedge mclk) seen_rd <= reg_rd && rst_n;
    always @(negedge mclk) begin
        if (seen_rd) begin
            if (exp_q.size() == 0) begin
                check("reg_rdata", {8'h00, reg_rdata}, 16'hffff);
            end else begin
                check("reg_rdata", {8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
            end
        end
    end

    // ==========================================================
    // register port, all entered at a falling edge
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        if (a >= `GAIN_ADDR && a <= `LOWER_THR_ADDR) shadow[a] = d;
        @(negedge mclk);
    endtask

    task automatic rd(input logic [5:0] a);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(shadow[a]);
        @(negedge mclk);
        reg_rd = 1'b0;
        @(negedge mclk);
    endtask

    // returns at the falling edge just after a sample tick has been taken
    task automatic tick_sync();
        int k;
        k = 0;
        while (sample_tick !== 1'b1 && k < 20) begin
            @(negedge mclk);
            k++;
        end
        if (k >= 20) check("sample_tick", 16'h0, 16'h1);
        @(negedge mclk);
    endtask

    task automatic do_reset();
        rst_n = 1'b0;
        repeat (16) @(negedge mclk);
        rst_n = 1'b1;
        for (int i = 0; i < 64; i++) shadow[i] = 8'h00;
        shadow[`GAIN_ADDR] = 8'h88;
        shadow[`HOWL_CTL_ADDR] = 8'h24;
        shadow[`UPPER_THR_ADDR] = 8'h30;
        shadow[`LOWER_THR_ADDR] = 8'h14;
        @(negedge mclk);
    endtask

    task automatic check_defaults();
        for (int a = 25; a <= 30; a++) rd(6'(a));
        check("transmit_gain_code", {12'h0, transmit_gain_code}, 16'h0008);
        check("receive_gain_code", {12'h0, receive_gain_code}, 16'h0008);
        check("attenuation_db", {11'h0, attenuation_db}, 16'h000c);
        check("upper_threshold_level", {9'h0, upper_threshold_level}, 16'h0030);
        check("lower_threshold_level", {9'h0, lower_threshold_level}, 16'h0014);
        check("howl_enable", {15'h0, howl_enable}, 16'h0000);
    endtask

    task automatic tone_step(input logic lo_en);
        logic [9:0] e_lo;
        logic [9:0] e_hi;
        p_lo = lower_tone_phase;
        p_hi = upper_tone_phase;
        tick_sync();
        e_lo = lo_en ? 10'(p_lo + shadow[`LOW_TONE_FREQUENCY_WORD_ADDR]) : 10'h000;
        e_hi = 10'(p_hi + shadow[`HIGH_TONE_FREQUENCY_WORD_ADDR]);
        check("lower_tone_phase", {6'h0, lower_tone_phase}, {6'h0, e_lo});
        check("upper_tone_phase", {6'h0, upper_tone_phase}, {6'h0, e_hi});
        // square tone is the top bit of the expected phase
        check("lower_tone_wave", {15'h0, lower_tone_wave}, {15'h0, e_lo[9]});
        check("upper_tone_wave", {15'h0, upper_tone_wave}, {15'h0, e_hi[9]});
    endtask

    // ==========================================================
    // main sequence
    initial begin
        r = $urandom(50706);
        do_reset();
        check_defaults();
        for (int c = 0; c < 16; c++) begin
            wr(`GAIN_ADDR, {4'(c), 4'(15 - c)});
            check("transmit_gain_code", {12'h0, transmit_gain_code}, 16'(c));
            check("tx_gain_db", {10'h0, tx_gain_db}, {10'h0, 6'(c * 3 - 24)});
            check("rx_gain_db", {10'h0, rx_gain_db}, {10'h0, 6'((15 - c) * 3 - 24)});
        end
        wr(`GAIN_ADDR, 8'h89);
        rd(`GAIN_ADDR);
        check("rx_gain_db", {10'h0, rx_gain_db}, 16'h0003);
        // every mode in both speech states, pad codes 0..7 along the way
        for (int m = 0; m < 4; m++) begin
            for (int s = 0; s < 2; s++) begin
                pad = m * 2 + s;
                wr(`HOWL_CTL_ADDR, {2'b10, 2'(m), 1'b0, 3'(pad)});
                speech_level = s ? 7'h7f : 7'h00;
                tick_sync();
                tick_sync();
                tx_e = ((m == 0 || m == 3) && s == 0) ? pad * 3 : 0;
                rx_e = ((m == 1 && s == 0) || (m >= 2 && s == 1)) ? pad * 3 : 0;
                check("howl_mode_select", {14'h0, howl_mode_select}, 16'(m));
                check("attenuation_db", {11'h0, attenuation_db}, 16'(pad * 3));
                check("attenuation_depth", {13'h0, attenuation_depth}, 16'(pad));
                check("speech_active", {15'h0, speech_active}, 16'(s));
                check("tx_atten_db", {11'h0, tx_atten_db}, 16'(tx_e));
                check("rx_atten_db", {11'h0, rx_atten_db}, 16'(rx_e));
            end
        end
        wr(`HOWL_CTL_ADDR, 8'h37);
        tick_sync();
        tick_sync();
        check("speech_active", {15'h0, speech_active}, 16'h0);
        check("tx_atten_db", {11'h0, tx_atten_db}, 16'h0);
        check("rx_atten_db", {11'h0, rx_atten_db}, 16'h0);
        wr(`HOWL_CTL_ADDR, 8'ha4);
        for (int i = 0; i < 8; i++) begin
            speech_level = LV[i];
            tick_sync();
            check("speech_active", {15'h0, speech_active}, {15'h0, ST[i]});
        end
        wr(`LOW_TONE_FREQUENCY_WORD_ADDR, 8'hff);
        wr(`HIGH_TONE_FREQUENCY_WORD_ADDR, 8'h07);
        lo_on = 1'b1;
        hi_on = 1'b1;
        tick_sync();
        repeat (2) tone_step(1'b1);
        wr(`LOW_TONE_FREQUENCY_WORD_ADDR, 8'($urandom));
        wr(`HIGH_TONE_FREQUENCY_WORD_ADDR, 8'($urandom));
        check("lower_tone_frequency_word", {8'h0, lower_tone_frequency_word},
              {8'h0, shadow[`LOW_TONE_FREQUENCY_WORD_ADDR]});
        check("upper_tone_frequency_word", {8'h0, upper_tone_frequency_word},
              {8'h0, shadow[`HIGH_TONE_FREQUENCY_WORD_ADDR]});
        tick_sync();
        repeat (2) tone_step(1'b1);
        lo_on = 1'b0;
        repeat (2) tone_step(1'b0);
        for (int i = 0; i < 12; i++) begin
            r = 25 + $urandom_range(5);
            wr(6'(r), 8'($urandom));
            rd(6'(r));
        end
        for (int a = 31; a < 64; a++) wr(6'(a), 8'($urandom));
        for (int a = 25; a < 64; a++) rd(6'(a));
        rd(6'h10);
        do_reset();
        check_defaults();
        repeat (2) @(negedge mclk);
        print_verdict();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        print_verdict();
    end
endmodule
`default_nettype wire
